//--- hdl/dm_top.v
// Column mask, test row patterns and frame counter behind a test access port
//
// Contract
// - A 640-bit mask; set bit blocks column latch and zeroes its output in matrix rows only.
// - Mask resets to zero; a one disables only that column.
// - Mask bit 639 is the leftmost column, bit 0 the rightmost.
// - Two 640-bit pattern registers, only bits 629 to 0 writable.
// - Pattern bits 639 to 630 read the frame counter, 0x200 after start.
// - Pattern-only mode sends pattern a and b alternately instead of matrix rows.
// - Line-marker mode appends two pattern rows after the last matrix row.
// - Reset clears bias, mask, mode and pattern registers to zero.
// - Reset puts the port controller in Test-Logic-Reset with identification selected.
// - Frame counter loads 0x200 on start, shifts right each frame.
`timescale 1ns/10ps
`include "dm_consts.vh"
module dm_top #(
    parameter COLS = `DM_COLS,
    parameter PAT_RW = `DM_PAT_RW,
    parameter BIAS_W = `DM_BIAS_W,
    parameter MODE_W = `DM_MODE_W,
    // Arbitrary value, names no maker or part
    parameter [31:0] ID_VALUE = 32'h0000_0001
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Test access port pins
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo_r,
    output reg tdo_oe_r,
    // Readout start pin
    input wire start,
    // Readout sequencer, same clock
    input wire row_strobe,
    input wire row_last,
    input wire frame_done,
    input wire [COLS-1:0] matrix_row,
    // Row output
    output reg [COLS-1:0] row_data_r,
    output reg row_valid_r,
    // Configuration outputs
    output wire [COLS-1:0] column_latch_block,
    output reg [`DM_FC_W-1:0] frame_count_r,
    output wire [BIAS_W-1:0] bias_codes,
    output wire [MODE_W-1:0] readout_mode_register_a,
    output wire [MODE_W-1:0] readout_mode_register_b
);
    // One-hot port controller states
    localparam [15:0] S_TLR = 16'h0001;
    localparam [15:0] S_RTI = 16'h0002;
    localparam [15:0] S_SDR = 16'h0004;
    localparam [15:0] S_CDR = 16'h0008;
    localparam [15:0] S_SHD = 16'h0010;
    localparam [15:0] S_E1D = 16'h0020;
    localparam [15:0] S_PD = 16'h0040;
    localparam [15:0] S_E2D = 16'h0080;
    localparam [15:0] S_UDR = 16'h0100;
    localparam [15:0] S_SIR = 16'h0200;
    localparam [15:0] S_CIR = 16'h0400;
    localparam [15:0] S_SHI = 16'h0800;
    localparam [15:0] S_E1I = 16'h1000;
    localparam [15:0] S_PI = 16'h2000;
    localparam [15:0] S_E2I = 16'h4000;
    localparam [15:0] S_UIR = 16'h8000;

    wire [3:0] pins_lv;
    reg tck_d_r;
    reg start_d_r;
    reg [15:0] st_r;
    reg [15:0] st_nxt;
    reg [`DM_IR_W-1:0] ir_r;
    reg [`DM_IR_W-1:0] ir_sh_r;
    reg [31:0] id_sh_r;
    reg byp_r;
    reg alt_r;
    reg [1:0] xtra_r;
    reg sel_so;

    wire tck_lv = pins_lv[0];
    wire tms_lv = pins_lv[1];
    wire tdi_lv = pins_lv[2];
    wire start_lv = pins_lv[3];
    wire tck_rise = tck_lv & ~tck_d_r;
    wire tck_fall = ~tck_lv & tck_d_r;
    wire start_rise = start_lv & ~start_d_r;

    // Scan strobes, one clock each per test clock rising edge
    wire cap_dr = tck_rise & st_r[3];
    wire sh_dr = tck_rise & st_r[4];
    wire upd_dr = tck_rise & st_r[8];

    wire [PAT_RW-1:0] pat_a_content;
    wire [PAT_RW-1:0] pat_b_content;
    wire so_mask;
    wire so_pat_a;
    wire so_pat_b;
    wire so_bias;
    wire so_mode_a;
    wire so_mode_b;

    // Emulated rows carry the live counter in their top bits
    wire [COLS-1:0] test_row_pattern_a = {frame_count_r, pat_a_content};
    wire [COLS-1:0] test_row_pattern_b = {frame_count_r, pat_b_content};
    wire pattern_only = readout_mode_register_a[`DM_MODE_PAT_ONLY];
    wire append_marker_rows_enable = readout_mode_register_a[`DM_MODE_MARKER];

    // Pins cross into the clock domain; test clock must dwell at least four clocks per level
    dm_sync #(
        .W(4)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .pin({start, tdi, tms, tck}),
        .level_r(pins_lv)
    );

    always @(posedge clk) begin
        if (reset) begin
            tck_d_r <= 1'b0;
            start_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_lv;
            start_d_r <= start_lv;
        end
    end

    // Port controller next state
    always @* begin
        case (st_r)
            S_TLR: st_nxt = tms_lv ? S_TLR : S_RTI;
            S_RTI: st_nxt = tms_lv ? S_SDR : S_RTI;
            S_SDR: st_nxt = tms_lv ? S_SIR : S_CDR;
            S_CDR: st_nxt = tms_lv ? S_E1D : S_SHD;
            S_SHD: st_nxt = tms_lv ? S_E1D : S_SHD;
            S_E1D: st_nxt = tms_lv ? S_UDR : S_PD;
            S_PD: st_nxt = tms_lv ? S_E2D : S_PD;
            S_E2D: st_nxt = tms_lv ? S_UDR : S_SHD;
            S_UDR: st_nxt = tms_lv ? S_SDR : S_RTI;
            S_SIR: st_nxt = tms_lv ? S_TLR : S_CIR;
            S_CIR: st_nxt = tms_lv ? S_E1I : S_SHI;
            S_SHI: st_nxt = tms_lv ? S_E1I : S_SHI;
            S_E1I: st_nxt = tms_lv ? S_UIR : S_PI;
            S_PI: st_nxt = tms_lv ? S_E2I : S_PI;
            S_E2I: st_nxt = tms_lv ? S_UIR : S_SHI;
            S_UIR: st_nxt = tms_lv ? S_SDR : S_RTI;
            default: st_nxt = S_TLR;
        endcase
    end

    // Controller, instruction register and the small fixed registers
    always @(posedge clk) begin
        if (reset) begin
            st_r <= S_TLR;
            ir_r <= `DM_INS_IDCODE;
            ir_sh_r <= {`DM_IR_W{1'b0}};
            id_sh_r <= 32'h0;
            byp_r <= 1'b0;
        end else if (tck_rise) begin
            st_r <= st_nxt;
            if (st_r == S_TLR) begin
                ir_r <= `DM_INS_IDCODE;
            end else if (st_r == S_CIR) begin
                ir_sh_r <= `DM_IR_CAPTURE;
            end else if (st_r == S_SHI) begin
                ir_sh_r <= {tdi_lv, ir_sh_r[`DM_IR_W-1:1]};
            end else if (st_r == S_UIR) begin
                ir_r <= ir_sh_r;
            end else if (st_r == S_CDR) begin
                id_sh_r <= ID_VALUE;
                byp_r <= 1'b0;
            end else if (st_r == S_SHD) begin
                id_sh_r <= {tdi_lv, id_sh_r[31:1]};
                byp_r <= tdi_lv;
            end
        end
    end

    // Column mask; bit index equals column, 639 leftmost, 0 rightmost
    dm_shreg #(
        .W(COLS),
        .RW(COLS)
    ) u_mask (
        .clk(clk),
        .reset(reset),
        .sel(ir_r == `DM_INS_MASK),
        .cap(cap_dr),
        .sh(sh_dr),
        .upd(upd_dr),
        .tdi(tdi_lv),
        .cap_val(column_latch_block),
        .so(so_mask),
        .hold_r(column_latch_block)
    );

    // Pattern registers; only the low part is writable
    dm_shreg #(
        .W(COLS),
        .RW(PAT_RW)
    ) u_pat_a (
        .clk(clk),
        .reset(reset),
        .sel(ir_r == `DM_INS_PAT_A),
        .cap(cap_dr),
        .sh(sh_dr),
        .upd(upd_dr),
        .tdi(tdi_lv),
        .cap_val(test_row_pattern_a),
        .so(so_pat_a),
        .hold_r(pat_a_content)
    );

    dm_shreg #(
        .W(COLS),
        .RW(PAT_RW)
    ) u_pat_b (
        .clk(clk),
        .reset(reset),
        .sel(ir_r == `DM_INS_PAT_B),
        .cap(cap_dr),
        .sh(sh_dr),
        .upd(upd_dr),
        .tdi(tdi_lv),
        .cap_val(test_row_pattern_b),
        .so(so_pat_b),
        .hold_r(pat_b_content)
    );

    // Sixteen 8-bit bias codes, code 0 in the low byte
    dm_shreg #(
        .W(BIAS_W),
        .RW(BIAS_W)
    ) u_bias (
        .clk(clk),
        .reset(reset),
        .sel(ir_r == `DM_INS_BIAS),
        .cap(cap_dr),
        .sh(sh_dr),
        .upd(upd_dr),
        .tdi(tdi_lv),
        .cap_val(bias_codes),
        .so(so_bias),
        .hold_r(bias_codes)
    );

    dm_shreg #(
        .W(MODE_W),
        .RW(MODE_W)
    ) u_mode_a (
        .clk(clk),
        .reset(reset),
        .sel(ir_r == `DM_INS_MODE_A),
        .cap(cap_dr),
        .sh(sh_dr),
        .upd(upd_dr),
        .tdi(tdi_lv),
        .cap_val(readout_mode_register_a),
        .so(so_mode_a),
        .hold_r(readout_mode_register_a)
    );

    dm_shreg #(
        .W(MODE_W),
        .RW(MODE_W)
    ) u_mode_b (
        .clk(clk),
        .reset(reset),
        .sel(ir_r == `DM_INS_MODE_B),
        .cap(cap_dr),
        .sh(sh_dr),
        .upd(upd_dr),
        .tdi(tdi_lv),
        .cap_val(readout_mode_register_b),
        .so(so_mode_b),
        .hold_r(readout_mode_register_b)
    );

    // Serial output select
    always @* begin
        case (ir_r)
            `DM_INS_IDCODE: sel_so = id_sh_r[0];
            `DM_INS_BIAS: sel_so = so_bias;
            `DM_INS_MODE_A: sel_so = so_mode_a;
            `DM_INS_MODE_B: sel_so = so_mode_b;
            `DM_INS_MASK: sel_so = so_mask;
            `DM_INS_PAT_A: sel_so = so_pat_a;
            `DM_INS_PAT_B: sel_so = so_pat_b;
            default: sel_so = byp_r;
        endcase
    end

    // Output changes on the falling test clock so the host samples a settled bit
    always @(posedge clk) begin
        if (reset) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_r <= st_r[4] | st_r[11];
            tdo_r <= st_r[11] ? ir_sh_r[0] : sel_so;
        end
    end

    // Frame counter; start wins over a coincident frame end
    always @(posedge clk) begin
        if (reset) begin
            frame_count_r <= `DM_FC_RST;
        end else if (start_rise) begin
            frame_count_r <= `DM_FC_INIT;
        end else if (frame_done) begin
            frame_count_r <= {1'b0, frame_count_r[`DM_FC_W-1:1]};
        end
    end

    // Row output; a strobe outranks pending marker rows, which then wait
    always @(posedge clk) begin
        if (reset) begin
            row_data_r <= `DM_MASK_RST;
            row_valid_r <= 1'b0;
            alt_r <= 1'b0;
            xtra_r <= 2'h0;
        end else begin
            row_valid_r <= 1'b0;
            if (start_rise) begin
                alt_r <= 1'b0;
                xtra_r <= 2'h0;
            end else if (row_strobe) begin
                row_valid_r <= 1'b1;
                if (pattern_only) begin
                    row_data_r <= alt_r ? test_row_pattern_b : test_row_pattern_a;
                    alt_r <= ~alt_r;
                end else begin
                    row_data_r <= matrix_row & ~column_latch_block;
                end
                if (row_last && append_marker_rows_enable) begin
                    xtra_r <= `DM_XTRA_ROWS;
                end
            end else if (xtra_r != 2'h0) begin
                row_valid_r <= 1'b1;
                row_data_r <= (xtra_r == `DM_XTRA_ROWS) ? test_row_pattern_a : test_row_pattern_b;
                xtra_r <= xtra_r - 2'h1;
            end
        end
    end
endmodule // dm_top

//--- hdl/dm_consts.vh
// Constants of the column mask and test row register bank
`ifndef DM_CONSTS_VH
`define DM_CONSTS_VH

// Geometry
`define DM_COLS 640
`define DM_PAT_RW 630
`define DM_FC_W 10
`define DM_BIAS_W 128
`define DM_MODE_W 8

// Reset values
`define DM_MASK_RST 640'h0
`define DM_PAT_RST 630'h0
`define DM_FC_RST 10'h000
`define DM_FC_INIT 10'h200

// Readout mode register a fields
`define DM_MODE_PAT_ONLY 0
`define DM_MODE_MARKER 1

// Instruction register
`define DM_IR_W 4
`define DM_IR_CAPTURE 4'h1
`define DM_INS_IDCODE 4'h1
`define DM_INS_BIAS 4'h2
`define DM_INS_MODE_A 4'h3
`define DM_INS_MODE_B 4'h4
`define DM_INS_MASK 4'h5
`define DM_INS_PAT_A 4'h6
`define DM_INS_PAT_B 4'h7
`define DM_INS_BYPASS 4'hf

// Extra marker rows per frame
`define DM_XTRA_ROWS 2'h2

`endif

//--- hdl/dm_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module dm_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Pins and filtered levels
    input wire [W-1:0] pin,
    output reg [W-1:0] level_r
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer i;

    // Stage one is read only by stage two
    always @(posedge clk) begin
        if (reset) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            level_r <= {W{1'b0}};
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_r[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // dm_sync

//--- hdl/dm_shreg.v
// Scan data register with capture, shift and update stages
`timescale 1ns/10ps
module dm_shreg #(
    parameter W = 8,
    parameter RW = 8
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Scan control, already gated to one clock per test clock rising edge
    input wire sel,
    input wire cap,
    input wire sh,
    input wire upd,
    input wire tdi,
    // Data
    input wire [W-1:0] cap_val,
    output wire so,
    output reg [RW-1:0] hold_r
);
    reg [W-1:0] shift_r;

    assign so = shift_r[0];

    always @(posedge clk) begin
        if (reset) begin
            shift_r <= {W{1'b0}};
            hold_r <= {RW{1'b0}};
        end else if (sel) begin
            if (cap) begin
                shift_r <= cap_val;
            end else if (sh) begin
                shift_r <= {tdi, shift_r[W-1:1]};
            end else if (upd) begin
                // Bits above RW are never stored, so read-only fields stay put
                hold_r <= shift_r[RW-1:0];
            end
        end
    end
endmodule // dm_shreg

//--- dv/dm_host.sv
// JTAG host model that loads the register bank through its test access port
`timescale 1ns/10ps
module dm_host (
    // Bench clock used to pace the pins
    input wire clk,
    // Test access port pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire tdo_r
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Levels last several clk so the pin filter of the device never misses an edge
    task automatic tick(input logic m, input logic b, output logic q);
        @(negedge clk);
        tck = 1'b0;
        tms = m;
        tdi = b;
        repeat (7) @(negedge clk);
        q = tdo_r;
        tck = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic go(input logic [3:0] seq, input int k);
        logic q;
        for (int i = 0; i < k; i++) begin
            tick(seq[i], 1'b0, q);
        end
    endtask
    task automatic shift(input logic [639:0] din, input int n, output logic [639:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
    endtask
    // Instruction 0 keeps the selected instruction; starts and ends in Run-Test/Idle
    task automatic scan(input logic [3:0] ir, input logic [639:0] din, input int n, output logic [639:0] dout);
        logic [639:0] junk;
        go(4'h1, 1);
        if (ir != 4'h0) begin
            // From Select-DR: Select-IR, Capture-IR, then into Shift-IR before the first bit
            go(4'h1, 3);
            shift({636'h0, ir}, 4, junk);
            go(4'h3, 2);
        end
        go(4'h0, 2);
        shift(din, n, dout);
        go(4'h1, 2);
    endtask
endmodule // dm_host

//--- dv/dm_top_asserts.sv
// Concurrent checks on the ports of the register bank
`timescale 1ns/10ps
module dm_top_asserts #(
    parameter COLS = 640,
    parameter BIAS_W = 128,
    parameter MODE_W = 8
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Pins
    input wire tck,
    input wire start,
    input wire row_strobe,
    input wire row_last,
    input wire frame_done,
    input wire [COLS-1:0] matrix_row,
    // Outputs
    input wire tdo_oe_r,
    input wire [COLS-1:0] row_data_r,
    input wire row_valid_r,
    input wire [COLS-1:0] column_latch_block,
    input wire [9:0] frame_count_r,
    input wire [BIAS_W-1:0] bias_codes,
    input wire [MODE_W-1:0] readout_mode_register_a
);
    reg [COLS-1:0] masked_r;
    wire [1:0] mode_w = readout_mode_register_a[1:0];
    always @(posedge clk) begin
        masked_r <= matrix_row & ~column_latch_block;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence last_row_s;
        row_strobe && row_last && mode_w == 2'b10;
    endsequence
    sequence marker_gap_s;
        last_row_s ##1 (!row_strobe) [*2];
    endsequence
    AST_NORMAL_ROW: assert property (row_strobe && !mode_w[0] |=> row_valid_r && row_data_r == masked_r)
        else $error("normal row not masked matrix row");
    AST_LEFT_COL: assert property (row_strobe && !mode_w[0] && column_latch_block[COLS-1] |=> !row_data_r[COLS-1])
        else $error("leftmost column not blocked");
    // Counter value as it stood at the strobe, so a coincident frame end does not trip it
    AST_PAT_ROW: assert property (row_strobe && mode_w == 2'b01 |=> row_valid_r && row_data_r[COLS-1 -: 10] == $past(frame_count_r))
        else $error("pattern row wrong");
    AST_MARKER: assert property (marker_gap_s |-> row_valid_r && row_data_r[COLS-1 -: 10] == frame_count_r ##1 row_valid_r)
        else $error("marker rows missing");
    AST_START_LOAD: assert property ($rose(start) |-> ##[3:7] frame_count_r == 10'h200)
        else $error("counter not loaded on start");
    AST_FRAME_SHIFT: assert property (frame_done && !start |=> frame_count_r == ($past(frame_count_r) >> 1))
        else $error("counter not shifted at frame end");
    AST_RESET: assert property (disable iff (1'b0) reset |=> column_latch_block == '0 && bias_codes == '0 && frame_count_r == '0 && readout_mode_register_a == '0 && !row_valid_r && !tdo_oe_r)
        else $error("registers not cleared by reset");
    AST_WRITE_ONLY: assert property (!$past(reset) && ($changed(column_latch_block) || $changed(bias_codes)) |-> tck || $past(tck))
        else $error("configuration changed without a scan update");
endmodule // dm_top_asserts
bind dm_top dm_top_asserts #(.COLS(COLS), .BIAS_W(BIAS_W), .MODE_W(MODE_W)) dm_top_asserts_i (.clk, .reset, .tck,
    .start, .row_strobe, .row_last, .frame_done, .matrix_row, .tdo_oe_r, .row_data_r, .row_valid_r,
    .column_latch_block, .frame_count_r, .bias_codes, .readout_mode_register_a);

//--- dv/test_dm_top.sv
// Self-checking bench for the column mask and test row register bank
`timescale 1ns/10ps
module test_dm_top;
    // Arbitrary value, names no maker or part
    localparam logic [31:0] ID_VAL = 32'h0000_5a5a;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic row_strobe = 1'b0;
    logic row_last = 1'b0;
    logic frame_done = 1'b0;
    logic [639:0] matrix_row = '0;
    logic [639:0] d, m, pa, pb;
    wire tck, tms, tdi, tdo_r, tdo_oe_r, row_valid_r;
    wire [639:0] row_data_r, column_latch_block;
    wire [9:0] frame_count_r;
    wire [127:0] bias_codes;
    wire [7:0] mode_a, mode_b;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    dm_host dm_host_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_r(tdo_r));
    dm_top #(.ID_VALUE(ID_VAL)) dm_top_i (.clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r), .start(start), .row_strobe(row_strobe), .row_last(row_last),
        .frame_done(frame_done), .matrix_row(matrix_row), .row_data_r(row_data_r), .row_valid_r(row_valid_r),
        .column_latch_block(column_latch_block), .frame_count_r(frame_count_r), .bias_codes(bias_codes),
        .readout_mode_register_a(mode_a), .readout_mode_register_b(mode_b));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Scans take about 49000 cycles in all
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 70000) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end
    task automatic check(input string what, input logic [639:0] seen, input logic [639:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rows(input logic s, input logic l);
        @(negedge clk);
        row_strobe = s;
        row_last = l;
    endtask
    // Start held 2100 ns; the counter loads on the filtered rising edge
    task automatic start_pulse();
        @(negedge clk);
        start = 1'b1;
        repeat (420) @(negedge clk);
        start = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        reset = 1'b0;
        repeat (5) @(negedge clk);
        check("bias", bias_codes, '0);
        check("mask", column_latch_block, '0);
        check("modes", {mode_a, mode_b}, '0);
        check("count", frame_count_r, '0);
        check("oe", tdo_oe_r, '0);
        dm_host_i.go(4'h0, 1);
        dm_host_i.scan(4'h0, '0, 32, d);
        check("id", d[31:0], ID_VAL);
        // Bias goes first, then the other registers, and readout only after both
        dm_host_i.scan(4'h2, {8{16'hc35a}}, 128, d);
        check("bias", bias_codes, {8{16'hc35a}});
        m = {1'b1, 319'h0, 1'b1, 318'h0, 1'b1};
        dm_host_i.scan(4'h5, m, 640, d);
        check("mask", column_latch_block, m);
        pa = {10'h3ff, {315{2'b10}}};
        pb = {10'h2aa, {315{2'b01}}};
        dm_host_i.scan(4'h6, pa, 640, d);
        dm_host_i.scan(4'h6, pa, 640, d);
        check("pattern a read", d, {10'h000, pa[629:0]});
        dm_host_i.scan(4'h7, pb, 640, d);
        dm_host_i.scan(4'h4, 8'ha5, 8, d);
        check("mode b", mode_b, 8'ha5);
        dm_host_i.scan(4'h3, 8'h02, 8, d);
        check("mode a", mode_a, 8'h02);
        start_pulse();
        check("count", frame_count_r, 10'h200);
        matrix_row = '1;
        rows(1'b1, 1'b1);
        rows(1'b0, 1'b0);
        check("row valid", row_valid_r, 1'b1);
        check("row", row_data_r, ~m);
        @(negedge clk);
        check("marker a", row_data_r, {10'h200, pa[629:0]});
        @(negedge clk);
        check("marker b", row_data_r, {10'h200, pb[629:0]});
        @(negedge clk);
        check("idle", row_valid_r, 1'b0);
        frame_done = 1'b1;
        @(negedge clk);
        frame_done = 1'b0;
        check("count", frame_count_r, 10'h100);
        dm_host_i.scan(4'h3, 8'h01, 8, d);
        start_pulse();
        rows(1'b1, 1'b0);
        rows(1'b1, 1'b0);
        check("pattern only a", row_data_r, {10'h200, pa[629:0]});
        rows(1'b0, 1'b0);
        check("pattern only b", row_data_r, {10'h200, pb[629:0]});
        dm_host_i.scan(4'h7, pb, 640, d);
        check("pattern b read", d, {10'h200, pb[629:0]});
        check("count kept", frame_count_r, 10'h200);
        summarize();
    end
endmodule // test_dm_top
